// ---- rtl/bscco_pkg.sv ----
// Shared constants and types for the bit skip, call and clear executor.
// Assumes a single 50 MHz clock and an instruction cycle of four phases.
package bscco_pkg;

	localparam int PC_W = 13;
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int LIT_W = 11;
	localparam int BIT_W = 3;
	localparam int LATCH_W = 8;

	// Field positions inside the instruction word and the counter latch
	localparam int SKIP_OP_LSB = 10;
	localparam int CALL_OP_LSB = 11;
	localparam int CLR_OP_LSB = 7;
	localparam int BIT_LSB = 7;
	localparam int FILE_LSB = 0;
	localparam int LIT_LSB = 0;
	localparam int LATCH_LSB = 3;

	// Opcode values
	localparam logic [3:0] OP_SKIP_SET = 4'h7;
	localparam logic [2:0] OP_CALL = 3'h4;
	localparam logic [6:0] OP_CLR_FILE = 7'h03;
	localparam logic [6:0] OP_CLR_W = 7'h02;
	localparam logic [13:0] INSTR_NOP = 14'h0000;

	// Values after reset, the clear value and the counter step
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic [7:0] CLEAR_VALUE = 8'h00;
	localparam logic [12:0] PC_STEP = 13'h0001;

	// Clock cycles per phase and per instruction cycle
	localparam int PHASE_CYCLES = 1;
	localparam int INSTR_CYCLES = 4 * PHASE_CYCLES;

	typedef enum logic [3:0] {
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} bscco_phase_t;

	typedef enum logic [1:0] {
		EX_RUN = 2'h1,
		EX_FLUSH = 2'h2
	} bscco_exec_t;

endpackage

// ---- rtl/bscco_phase_if.sv ----
// Carries the current instruction phase from the phase generator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface bscco_phase_if;
	bscco_pkg::bscco_phase_t phase;
	modport gen (output phase);
	modport core (input phase);
endinterface

// ---- rtl/bscco_phase_gen.sv ----
// Four-phase generator: one phase per clock, Q1 to Q4, then again.
// Assumes a synchronous active-low reset on the same clock.
`timescale 1ns/1ps
module bscco_phase_gen (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	bscco_phase_if.gen ph
);
	typedef struct packed {
		bscco_pkg::bscco_phase_t phase;
	} bscco_gen_state_t;

	bscco_gen_state_t s_reg;
	bscco_gen_state_t s_next;

	always_comb begin
		s_next = s_reg;
		case (s_reg.phase)
			bscco_pkg::PH_Q1: s_next.phase = bscco_pkg::PH_Q2;
			bscco_pkg::PH_Q2: s_next.phase = bscco_pkg::PH_Q3;
			bscco_pkg::PH_Q3: s_next.phase = bscco_pkg::PH_Q4;
			default: s_next.phase = bscco_pkg::PH_Q1;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			s_reg.phase <= bscco_pkg::PH_Q1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign ph.phase = s_reg.phase;

	a_phase_order: assert property (@(posedge clk_sys_i)
		disable iff (!reset_n_i)
		s_reg.phase == bscco_pkg::PH_Q1 |=> s_reg.phase == bscco_pkg::PH_Q2)
		else $error("phase Q2 did not follow Q1");
endmodule // bscco_phase_gen

// ---- rtl/bscco_core.sv ----
// Executor for skip-if-bit-set, call, clear file and clear working reg.
// Assumes program memory and file registers answer in the same clock.
// Functional notes
// - Skip on bit clear: next instruction runs normally, one cycle.
// - Skip on bit set: next instruction becomes a no-op, two cycles.
// - Clear file writes zero to file address 0..127, sets zero flag.
// - Call loads 11-bit literal into counter 10:0, latch 4:3 into 12:11.
`timescale 1ns/1ps
module bscco_core (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic [13:0] instr_i,
	output logic fetch_o,
	output logic [12:0] program_counter_o,
	input wire logic [7:0] file_rdata_i,
	output logic [6:0] file_addr_o,
	output logic [7:0] file_wdata_o,
	output logic file_we_o,
	input wire logic [7:0] program_counter_latch_high_i,
	output logic stack_push_o,
	output logic [12:0] top_of_stack_o,
	output logic [7:0] working_o,
	output logic zero_o,
	output logic flushing_o,
	output logic [3:0] phase_o
);
	typedef struct packed {
		bscco_pkg::bscco_exec_t mode;
		logic [13:0] instr;
		logic [7:0] fdata;
		logic [12:0] pc;
		logic [7:0] w;
		logic z;
		logic [6:0] addr;
		logic [7:0] wdata;
		logic we;
		logic push;
		logic [12:0] push_data;
		logic hold;
	} bscco_core_state_t;

	bscco_core_state_t s_reg;
	bscco_core_state_t s_next;
	bscco_phase_if ph ();

	bscco_phase_gen u_phase (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.ph(ph.gen)
	);

	logic is_skip;
	logic is_call;
	logic is_clr_file;
	logic is_clr_w;
	logic bit_set;
	logic [2:0] bit_sel;
	logic [12:0] call_target;
	logic [12:0] pc_plus_one;

	assign is_skip = s_reg.instr[13:bscco_pkg::SKIP_OP_LSB]
		== bscco_pkg::OP_SKIP_SET;
	assign is_call = s_reg.instr[13:bscco_pkg::CALL_OP_LSB]
		== bscco_pkg::OP_CALL;
	assign is_clr_file = s_reg.instr[13:bscco_pkg::CLR_OP_LSB]
		== bscco_pkg::OP_CLR_FILE;
	assign is_clr_w = s_reg.instr[13:bscco_pkg::CLR_OP_LSB]
		== bscco_pkg::OP_CLR_W;
	assign bit_sel = s_reg.instr[bscco_pkg::BIT_LSB +: bscco_pkg::BIT_W];
	assign bit_set = s_reg.fdata[bit_sel];
	assign call_target = {
		program_counter_latch_high_i[bscco_pkg::LATCH_LSB +: 2],
		s_reg.instr[bscco_pkg::LIT_LSB +: bscco_pkg::LIT_W]};
	assign pc_plus_one = s_reg.pc + bscco_pkg::PC_STEP;

	always_comb begin
		s_next = s_reg;
		s_next.we = 1'b0;
		s_next.push = 1'b0;
		case (ph.phase)
			bscco_pkg::PH_Q1: begin
				// Decode; a flushed slot decodes as a no-op
				if (s_reg.mode == bscco_pkg::EX_FLUSH) begin
					s_next.instr = bscco_pkg::INSTR_NOP;
				end else begin
					s_next.instr = instr_i;
				end
				s_next.addr = instr_i[bscco_pkg::FILE_LSB +: bscco_pkg::ADDR_W];
			end
			bscco_pkg::PH_Q2: begin
				s_next.fdata = file_rdata_i;
			end
			bscco_pkg::PH_Q3: begin
				if (is_clr_file) begin
					s_next.wdata = bscco_pkg::CLEAR_VALUE;
					s_next.we = 1'b1;
				end
				if (is_call) begin
					s_next.push = 1'b1;
					s_next.push_data = pc_plus_one;
				end
			end
			bscco_pkg::PH_Q4: begin
				s_next.mode = bscco_pkg::EX_RUN;
				s_next.hold = 1'b0;
				// Call's no-op slot keeps the counter on the target
				s_next.pc = s_reg.hold ? s_reg.pc : pc_plus_one;
				if (is_clr_file) begin
					s_next.z = 1'b1;
				end
				if (is_clr_w) begin
					s_next.w = bscco_pkg::CLEAR_VALUE;
					s_next.z = 1'b1;
				end
				if (is_call) begin
					s_next.pc = call_target;
					s_next.mode = bscco_pkg::EX_FLUSH;
					s_next.hold = 1'b1;
				end
				if (is_skip && bit_set) begin
					s_next.mode = bscco_pkg::EX_FLUSH;
				end
			end
			default: begin
				s_next = s_reg;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			s_reg.mode <= bscco_pkg::EX_RUN;
			s_reg.instr <= bscco_pkg::INSTR_NOP;
			s_reg.fdata <= bscco_pkg::CLEAR_VALUE;
			s_reg.pc <= bscco_pkg::PC_RESET;
			s_reg.w <= bscco_pkg::W_RESET;
			s_reg.z <= 1'b0;
			s_reg.addr <= 7'h00;
			s_reg.wdata <= bscco_pkg::CLEAR_VALUE;
			s_reg.we <= 1'b0;
			s_reg.push <= 1'b0;
			s_reg.push_data <= bscco_pkg::PC_RESET;
			s_reg.hold <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign fetch_o = ph.phase == bscco_pkg::PH_Q1;
	assign program_counter_o = s_reg.pc;
	assign file_addr_o = s_reg.addr;
	assign file_wdata_o = s_reg.wdata;
	assign file_we_o = s_reg.we;
	assign stack_push_o = s_reg.push;
	assign top_of_stack_o = s_reg.push_data;
	assign working_o = s_reg.w;
	assign zero_o = s_reg.z;
	assign flushing_o = s_reg.mode == bscco_pkg::EX_FLUSH;
	assign phase_o = ph.phase;

	// Helpers for the checks below
	logic at_q3;
	logic at_q4;
	logic [12:0] pc_seen;
	assign at_q3 = ph.phase == bscco_pkg::PH_Q3;
	assign at_q4 = ph.phase == bscco_pkg::PH_Q4;
	assign pc_seen = s_reg.pc;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_flush_slot;
		flushing_o [*4];
	endsequence

	sequence s_run_slot;
		!flushing_o [*4];
	endsequence

	a_skip_clear_runs: assert property (
		at_q4 && is_skip && !bit_set |=> s_run_slot ##0 pc_seen
			== $past(pc_plus_one, 4))
		else $error("skip on clear bit lost the next instruction");

	a_skip_set_flush: assert property (
		at_q4 && is_skip && bit_set |=> s_flush_slot ##1 !flushing_o)
		else $error("skip on set bit did not flush one cycle");

	a_clear_file_register_write: assert property (
		at_q3 && is_clr_file |=> file_we_o && file_wdata_o == 8'h00
			&& file_addr_o == $past(s_reg.addr) ##1 !file_we_o && zero_o)
		else $error("clear file did not write zero and set zero flag");

	a_clear_working_register_zero: assert property (
		at_q3 && is_clr_w |=> !file_we_o ##1 working_o == 8'h00 && zero_o)
		else $error("clear working register failed");

	a_call_target: assert property (
		at_q4 && is_call |=> program_counter_o == $past(call_target))
		else $error("call target not loaded into counter");

	a_call_push: assert property (
		at_q3 && is_call |=> stack_push_o
			&& top_of_stack_o == program_counter_o + 13'h0001)
		else $error("call did not push counter plus one");

	a_call_flush: assert property (
		at_q4 && is_call |=> s_flush_slot)
		else $error("call second cycle was not a no-op");

	a_flush_nop: assert property (
		fetch_o && flushing_o |=> s_reg.instr == 14'h0000 ##2 !file_we_o)
		else $error("flushed slot did not decode as no-op");

	a_flush_quiet: assert property (
		at_q4 && flushing_o |-> !file_we_o && !stack_push_o)
		else $error("flushed slot wrote a file or pushed the stack");

	a_call_lands: assert property (
		at_q4 && is_call |=> ##4 program_counter_o == $past(call_target, 5))
		else $error("counter left the call target before its first fetch");
endmodule // bscco_core

// ---- testbench/bscco_tb.sv ----
// Self-checking bench for the skip, call and clear executor core.
// Drives the core ports directly; one instruction every four clocks.
`timescale 1ns/1ps
module testbench;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [13:0] instr_i = 14'h0000;
	logic [7:0] file_rdata_i = 8'h00;
	logic [7:0] latch_high = 8'h00;
	logic fetch_o, file_we_o, stack_push_o, zero_o, flushing_o;
	logic [12:0] program_counter_o, top_of_stack_o;
	logic [6:0] file_addr_o;
	logic [7:0] file_wdata_o, working_o;
	logic [3:0] phase_o;
	int miscompares = 0;
	int checks = 0;
	logic [12:0] pc_m = 13'h0000;
	logic z_m = 1'b0;
	logic fl_m = 1'b0;
	logic hd_m = 1'b0;

	bscco_core u_bscco_core (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.instr_i(instr_i),
		.fetch_o(fetch_o),
		.program_counter_o(program_counter_o),
		.file_rdata_i(file_rdata_i),
		.file_addr_o(file_addr_o),
		.file_wdata_o(file_wdata_o),
		.file_we_o(file_we_o),
		.program_counter_latch_high_i(latch_high),
		.stack_push_o(stack_push_o),
		.top_of_stack_o(top_of_stack_o),
		.working_o(working_o),
		.zero_o(zero_o),
		.flushing_o(flushing_o),
		.phase_o(phase_o)
	);

	initial begin
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	task automatic summarize();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic step();
		@(posedge clk_sys_i);
		#1;
	endtask

	// One instruction cycle, entered one delay after its Q1 edge
	task automatic run(input logic [13:0] op, input logic [7:0] rd,
		input logic [7:0] lt);
		logic skp, cal, clf, clw, nf;
		instr_i = op;
		file_rdata_i = rd;
		latch_high = lt;
		skp = !fl_m && op[13:10] == 4'h7;
		cal = !fl_m && op[13:11] == 3'h4;
		clf = !fl_m && op[13:7] == 7'h03;
		clw = !fl_m && op[13:7] == 7'h02;
		chk(program_counter_o, pc_m);
		chk(13'(phase_o), 13'h0001);
		step();
		if (clf) chk(13'(file_addr_o), 13'(op[6:0]));
		step();
		step();
		chk(13'(file_we_o), 13'(clf));
		if (clf) chk(13'(file_wdata_o), 13'h0000);
		chk(13'(stack_push_o), 13'(cal));
		if (cal) chk(top_of_stack_o, pc_m + 13'h0001);
		nf = cal || (skp && rd[op[9:7]]);
		pc_m = cal ? {lt[4:3], op[10:0]}
			: (hd_m ? pc_m : pc_m + 13'h0001);
		hd_m = cal;
		z_m = z_m | clf | clw;
		fl_m = nf;
		step();
		chk(13'(flushing_o), 13'(fl_m));
		chk(13'(zero_o), 13'(z_m));
		chk(13'(working_o), 13'h0000);
	endtask

	initial begin
		int kind;
		logic [13:0] op;
		void'($urandom(32'h949b2666));
		repeat (3) @(posedge clk_sys_i);
		#1;
		reset_n_i = 1'b1;
		run(14'h01FF, 8'h5A, 8'h00);
		run(14'h0100, 8'h00, 8'h00);
		run(14'h1F85, 8'h7F, 8'h00);
		run(14'h1F85, 8'h80, 8'h00);
		run(14'h0185, 8'h00, 8'h00);
		run(14'h27FF, 8'h00, 8'h18);
		run(14'h0180, 8'h00, 8'h00);
		run(14'h2000, 8'h00, 8'hE7);
		run(14'h0000, 8'h00, 8'h00);
		repeat (200) begin
			kind = $urandom % 4;
			case (kind)
				0: op = {4'h7, 3'($urandom), 7'($urandom)};
				1: op = {3'h4, 11'($urandom)};
				2: op = {7'h03, 7'($urandom)};
				default: op = {7'h02, 7'($urandom)};
			endcase
			run(op, 8'($urandom), 8'($urandom));
		end
		reset_n_i = 1'b0;
		step();
		reset_n_i = 1'b1;
		pc_m = 13'h0000;
		z_m = 1'b0;
		fl_m = 1'b0;
		hd_m = 1'b0;
		run(14'h0000, 8'h00, 8'h00);
		run(14'h0100, 8'h00, 8'h00);
		summarize();
	end

	// Watchdog well beyond the expected run of about 850 clocks
	initial begin
		#40000;
		miscompares++;
		summarize();
	end
endmodule // testbench
